// ### verilog/tal_pkg.sv
// Constants shared by the temperature alarm and interrupt logic
package tal_pkg;
  // ****************************************
  // Bus addresses and register pointers
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h4c;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [7:0] RA_LOCAL = 8'h00;
  localparam logic [7:0] RA_REMOTE = 8'h01;
  localparam logic [7:0] RA_STATUS = 8'h02;
  localparam logic [7:0] RA_CONFIG = 8'h03;
  localparam logic [7:0] RA_LHI = 8'h05;
  localparam logic [7:0] RA_LLO = 8'h06;
  localparam logic [7:0] RA_RHI = 8'h07;
  localparam logic [7:0] RA_RLO = 8'h08;
  localparam logic [7:0] WA_CONFIG = 8'h09;
  localparam logic [7:0] WA_LHI = 8'h0b;
  localparam logic [7:0] WA_LLO = 8'h0c;
  localparam logic [7:0] WA_RHI = 8'h0d;
  localparam logic [7:0] WA_RLO = 8'h0e;
  localparam logic [7:0] WA_ONESHOT = 8'h0f;
  localparam logic [7:0] A_OVT_REMOTE = 8'h19;
  localparam logic [7:0] A_OVT_LOCAL = 8'h20;
  localparam logic [7:0] A_HYST = 8'h21;
  localparam logic [7:0] RA_ID = 8'hfe;
  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_HI = 8'h55;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam logic [7:0] RST_OVT_REMOTE = 8'h6c;
  localparam logic [7:0] RST_OVT_LOCAL = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0a;
  localparam int CFG_MASK = 7;
  localparam int CFG_STANDBY = 6;
  localparam int CFG_PIN_MODE = 5;
  localparam int ST_BUSY = 7;
  localparam int ST_LHI = 6;
  localparam int ST_LLO = 5;
  localparam int ST_RHI = 4;
  localparam int ST_RLO = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_ROT = 1;
  localparam int ST_LOT = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_MHZ = 20;
  localparam int CONV_INTERVAL_US = 62500;
  localparam int CONV_GAP_CYCLES = CONV_INTERVAL_US * CLK_FREQ_MHZ;
  localparam int TIMER_W = 21;
endpackage : tal_pkg

// ### verilog/tal_conv_link.sv
// Converter-side sequencing on the converter clock
module tal_conv_link (
  input wire logic adc_clk_in,
  input wire logic nrst_in,
  input wire logic start_tgl_in,
  input wire logic abort_in,
  input wire logic adc_done_in,
  input wire logic [7:0] adc_local_in,
  input wire logic [7:0] adc_remote_in,
  input wire logic diode_open_in,
  output logic adc_start_out,
  output logic done_tgl_out,
  output logic open_out,
  output logic [7:0] local_out,
  output logic [7:0] remote_out
);
  logic [2:0] start_q;
  logic [1:0] abort_q;
  logic [1:0] open_q;
  logic run_q;
  wire start_w = (start_q[2] ^ start_q[1]) & ~abort_q[1];

  always_ff @(posedge adc_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_q <= 3'h0;
      abort_q <= 2'h0;
      open_q <= 2'h0;
    end else begin
      start_q <= {start_q[1:0], start_tgl_in};
      abort_q <= {abort_q[0], abort_in};
      open_q <= {open_q[0], diode_open_in};
    end
  end

  // Results are held until the next finished conversion so the core can read them late
  always_ff @(posedge adc_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_q <= 1'b0;
      adc_start_out <= 1'b0;
      done_tgl_out <= 1'b0;
      open_out <= 1'b0;
      local_out <= 8'h00;
      remote_out <= 8'h00;
    end else begin
      adc_start_out <= start_w;
      if (start_w) begin
        run_q <= 1'b1;
        open_out <= open_q[1];
      end else if (abort_q[1]) begin
        run_q <= 1'b0;
      end else if (run_q && adc_done_in) begin
        run_q <= 1'b0;
        local_out <= adc_local_in;
        remote_out <= adc_remote_in;
        done_tgl_out <= ~done_tgl_out;
      end
    end
  end
endmodule // tal_conv_link

// ### verilog/tal_serial_slave.sv
// Two-wire serial slave with alert response answering
module tal_serial_slave
  import tal_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ara_en_in,
  input wire logic [7:0] rd_data_in,
  output logic sda_oe_out,
  output logic wr_out,
  output logic [7:0] ptr_out,
  output logic [7:0] wdata_out,
  output logic rd_done_out,
  output logic ara_done_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ} tal_bus_state_t;
  tal_bus_state_t state_q;
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic ptr_phase_q;
  logic ara_q;
  logic nack_q;
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire start_w = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  wire stop_w = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  wire dev_hit = shift_q[7:1] == DEV_ADDR;
  wire ara_hit = (shift_q[7:1] == ARA_ADDR) & shift_q[0] & ara_en_in;
  wire active_w = state_q != ST_IDLE;
  // Sending a one while the line reads low means a lower address won
  wire lost_w = scl_rise & (state_q == ST_READ) & (cnt_q < 4'h8) & ~sda_oe_out & ~sda_q[1];
  wire [7:0] ara_byte = {DEV_ADDR, 1'b1};

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_phase_q <= 1'b0;
      ara_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_out <= 1'b0;
      wr_out <= 1'b0;
      ptr_out <= 8'h00;
      wdata_out <= 8'h00;
      rd_done_out <= 1'b0;
      ara_done_out <= 1'b0;
    end else begin
      wr_out <= 1'b0;
      rd_done_out <= 1'b0;
      ara_done_out <= 1'b0;
      if (start_w) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_w || lost_w) begin
        state_q <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else if (active_w && scl_rise) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q < 4'h8) begin
          shift_q <= {shift_q[6:0], sda_q[1]};
        end else begin
          nack_q <= sda_q[1];
        end
      end else if (active_w && scl_fall) begin
        if (cnt_q == 4'h8) begin
          unique case (state_q)
            ST_ADDR: begin
              if (dev_hit || ara_hit) begin
                sda_oe_out <= 1'b1;
                ara_q <= ara_hit & ~dev_hit;
                ptr_phase_q <= 1'b1;
                state_q <= shift_q[0] ? ST_READ : ST_WRITE;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_WRITE: begin
              sda_oe_out <= 1'b1;
              ptr_phase_q <= 1'b0;
              if (ptr_phase_q) begin
                ptr_out <= shift_q;
              end else begin
                wr_out <= 1'b1;
                wdata_out <= shift_q;
              end
            end
            ST_READ: begin
              sda_oe_out <= 1'b0;
              ara_done_out <= ara_q;
              rd_done_out <= ~ara_q;
            end
            ST_IDLE: begin
            end
          endcase
        end else if (cnt_q == 4'h9) begin
          cnt_q <= 4'h0;
          if (state_q == ST_READ && !nack_q) begin
            tx_q <= ara_q ? ara_byte : rd_data_in;
            sda_oe_out <= ara_q ? ~ara_byte[7] : ~rd_data_in[7];
          end else begin
            sda_oe_out <= 1'b0;
            if (state_q == ST_READ) begin
              state_q <= ST_IDLE;
            end
          end
        end else if (state_q == ST_READ) begin
          sda_oe_out <= ~tx_q[3'h7 - cnt_q[2:0]];
        end
      end
    end
  end
endmodule // tal_serial_slave

// ### verilog/tal_interrupt_logic.sv
// Alarm, overtemperature and conversion control of a two-channel temperature monitor
//
// Operation
// - Limit interrupt low on limit or open fault
// - Limit interrupt only pulls low, else floats
// - Master reads alert address; asserting device acknowledges
// - Alert answer is own address followed by a one bit
// - Lowest address wins alert answer arbitration
// - Release after answer only if fault gone
// - Standby stops converter, drops running conversion
// - One-shot write converts once in standby
// - Limit writes re-evaluate stored temperatures immediately
// - Sample open comparator at conversion start
// - Limit interrupt maskable, overtemperature output not
// - Violation above high or at/below low
// - Interrupt holds until serviced, cleared, status reset
// - Overtemperature low when either channel exceeds
// - Overtemperature releases at limit minus hysteresis
// - Hysteresis unsigned, one degree, default ten
// - Pin selects limit interrupt or second overtemperature
// - Second overtemperature uses high limits, same hysteresis
// - Fixed bus address answered and returned
// - Local high limit defaults to 85 degrees
module tal_interrupt_logic
  import tal_pkg::*;
#(
  parameter int unsigned CONV_GAP = CONV_GAP_CYCLES
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o_out,
  output logic sda_oe_out,
  input wire logic adc_clk_in,
  input wire logic adc_done_in,
  input wire logic [7:0] adc_local_in,
  input wire logic [7:0] adc_remote_in,
  input wire logic diode_open_in,
  output logic adc_start_out,
  output logic limit_pin_o_out,
  output logic limit_pin_oe_out,
  output logic overtemp_o_out,
  output logic overtemp_oe_out
);
  localparam logic [TIMER_W-1:0] GAP_LAST = TIMER_W'(CONV_GAP - 1);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic above(input logic [7:0] t, input logic [7:0] lim);
    above = $signed(t) > $signed(lim);
  endfunction

  function automatic logic released(input logic [7:0] t, input logic [7:0] lim,
                                    input logic [7:0] hyst);
    released = $signed({t[7], t[7], t}) <= ($signed({lim[7], lim[7], lim})
               - $signed({2'b00, hyst}));
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] cfg_q;
  logic [7:0] lhi_q;
  logic [7:0] llo_q;
  logic [7:0] rhi_q;
  logic [7:0] rlo_q;
  logic [7:0] ovt_l_q;
  logic [7:0] ovt_r_q;
  logic [7:0] hyst_q;
  logic [7:0] local_q;
  logic [7:0] remote_q;
  logic [6:0] status_q;
  logic valid_q;
  logic busy_q;
  logic oneshot_q;
  logic abort_q;
  logic start_tgl_q;
  logic [TIMER_W-1:0] timer_q;
  logic [2:0] done_q;
  logic [1:0] open_q;
  logic alert_q;
  logic serviced_q;
  logic pin_q;
  logic ovt_pin_q;
  logic zero_q;
  logic [3:0] hys_w;
  logic wr_w;
  logic rd_done_w;
  logic ara_done_w;
  logic [7:0] ptr_w;
  logic [7:0] wdata_w;
  logic link_done_tgl;
  logic link_open;
  logic [7:0] link_local;
  logic [7:0] link_remote;
  logic [7:0] rd_data_w;

  // ****************************************
  // Serial slave and converter link
  // ****************************************
  tal_serial_slave u_slave (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ara_en_in(pin_q & ~cfg_q[CFG_PIN_MODE]),
    .rd_data_in(rd_data_w),
    .sda_oe_out(sda_oe_out),
    .wr_out(wr_w),
    .ptr_out(ptr_w),
    .wdata_out(wdata_w),
    .rd_done_out(rd_done_w),
    .ara_done_out(ara_done_w)
  );

  tal_conv_link u_link (
    .adc_clk_in(adc_clk_in),
    .nrst_in(nrst_in),
    .start_tgl_in(start_tgl_q),
    .abort_in(abort_q),
    .adc_done_in(adc_done_in),
    .adc_local_in(adc_local_in),
    .adc_remote_in(adc_remote_in),
    .diode_open_in(diode_open_in),
    .adc_start_out(adc_start_out),
    .done_tgl_out(link_done_tgl),
    .open_out(link_open),
    .local_out(link_local),
    .remote_out(link_remote)
  );

  // ****************************************
  // Decode
  // ****************************************
  wire standby_w = cfg_q[CFG_STANDBY];
  wire masked_w = cfg_q[CFG_MASK];
  wire second_mode_w = cfg_q[CFG_PIN_MODE];
  wire done_w = (done_q[2] ^ done_q[1]) & busy_q;
  wire open_w = open_q[1];
  wire oneshot_wr = wr_w & (ptr_w == WA_ONESHOT);
  wire status_rd = rd_done_w & (ptr_w == RA_STATUS);
  wire timer_hit = timer_q == GAP_LAST;
  wire launch_w = ~busy_q & ~abort_q & (oneshot_q | (~standby_w & timer_hit));
  wire l_hi = valid_q & above(local_q, lhi_q);
  wire l_lo = valid_q & ($signed(local_q) <= $signed(llo_q));
  wire r_hi = valid_q & above(remote_q, rhi_q);
  wire r_lo = valid_q & ($signed(remote_q) <= $signed(rlo_q));
  wire alarm_live = l_hi | l_lo | r_hi | r_lo | open_w;
  wire [6:0] status_set = {l_hi, l_lo, r_hi, r_lo, open_w, hys_w[1], hys_w[0]};
  wire [6:0] status_clr = status_rd ? 7'h7f : 7'h00;
  wire [7:0] cmp_temp [4] = '{local_q, remote_q, local_q, remote_q};
  wire [7:0] cmp_lim [4] = '{ovt_l_q, ovt_r_q, lhi_q, rhi_q};

  function automatic logic [7:0] read_mux(input logic [7:0] ptr);
    unique case (ptr)
      RA_LOCAL: read_mux = local_q;
      RA_REMOTE: read_mux = remote_q;
      RA_STATUS: read_mux = {busy_q, status_q};
      RA_CONFIG: read_mux = cfg_q;
      RA_LHI: read_mux = lhi_q;
      RA_LLO: read_mux = llo_q;
      RA_RHI: read_mux = rhi_q;
      RA_RLO: read_mux = rlo_q;
      A_OVT_REMOTE: read_mux = ovt_r_q;
      A_OVT_LOCAL: read_mux = ovt_l_q;
      A_HYST: read_mux = hyst_q;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // A process, so a change of a stored value retriggers the mux, not only the pointer
  always_comb rd_data_w = read_mux(ptr_w);

  // ****************************************
  // Register writes
  // ****************************************
  // Limits take effect at once; comparisons run on stored values every cycle
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_q <= RST_CONFIG;
      lhi_q <= RST_HI;
      llo_q <= RST_LO;
      rhi_q <= RST_HI;
      rlo_q <= RST_LO;
      ovt_l_q <= RST_OVT_LOCAL;
      ovt_r_q <= RST_OVT_REMOTE;
      hyst_q <= RST_HYST;
    end else if (wr_w) begin
      unique case (ptr_w)
        WA_CONFIG: cfg_q <= wdata_w;
        WA_LHI: lhi_q <= wdata_w;
        WA_LLO: llo_q <= wdata_w;
        WA_RHI: rhi_q <= wdata_w;
        WA_RLO: rlo_q <= wdata_w;
        A_OVT_LOCAL: ovt_l_q <= wdata_w;
        A_OVT_REMOTE: ovt_r_q <= wdata_w;
        A_HYST: hyst_q <= wdata_w;
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Conversion control
  // ****************************************
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_q <= 3'h0;
      open_q <= 2'h0;
      timer_q <= '0;
      abort_q <= 1'b1;
      start_tgl_q <= 1'b0;
    end else begin
      done_q <= {done_q[1:0], link_done_tgl};
      open_q <= {open_q[0], link_open};
      timer_q <= timer_hit ? '0 : timer_q + 1'b1;
      abort_q <= standby_w & ~oneshot_q;
      start_tgl_q <= start_tgl_q ^ launch_w;
    end
  end

  // Abort is low a cycle before any start toggle, so the link never drops one
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_q <= 1'b0;
      oneshot_q <= 1'b0;
      valid_q <= 1'b0;
      local_q <= 8'h00;
      remote_q <= 8'h00;
    end else begin
      if (launch_w) begin
        busy_q <= 1'b1;
      end else if (done_w || abort_q) begin
        busy_q <= 1'b0;
      end
      if (oneshot_wr) begin
        oneshot_q <= 1'b1;
      end else if (done_w) begin
        oneshot_q <= 1'b0;
      end
      if (done_w) begin
        valid_q <= 1'b1;
        local_q <= link_local;
        remote_q <= link_remote;
      end
    end
  end

  // ****************************************
  // Overtemperature comparators
  // ****************************************
  for (genvar g = 0; g < 4; g++) begin : g_hys
    logic q;
    always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
        q <= 1'b0;
      end else if (valid_q && above(cmp_temp[g], cmp_lim[g])) begin
        q <= 1'b1;
      end else if (released(cmp_temp[g], cmp_lim[g], hyst_q)) begin
        q <= 1'b0;
      end
    end
    assign hys_w[g] = q;
  end

  // ****************************************
  // Status and limit interrupt
  // ****************************************
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_q <= 7'h00;
      alert_q <= 1'b0;
      serviced_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
      if (alarm_live && !masked_w) begin
        alert_q <= 1'b1;
      end else if (serviced_q && status_q[6:2] == 5'h00) begin
        alert_q <= 1'b0;
      end
      if (!alert_q) begin
        serviced_q <= 1'b0;
      end else if (ara_done_w) begin
        serviced_q <= 1'b1;
      end
    end
  end

  // Pins only ever pull low; the o level is a constant zero
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      zero_q <= 1'b0;
      pin_q <= 1'b0;
      ovt_pin_q <= 1'b0;
    end else begin
      zero_q <= 1'b0;
      pin_q <= second_mode_w ? (hys_w[2] | hys_w[3]) : (alert_q & ~masked_w);
      ovt_pin_q <= hys_w[0] | hys_w[1];
    end
  end

  assign sda_o_out = zero_q;
  assign limit_pin_o_out = zero_q;
  assign limit_pin_oe_out = pin_q;
  assign overtemp_o_out = zero_q;
  assign overtemp_oe_out = ovt_pin_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  AST_OT_SET: assert property ((valid_q && above(local_q, ovt_l_q)) |-> ##2 overtemp_oe_out)
    else $error("overtemp pin not low after local overtemp");
  AST_OT_REL: assert property ((released(local_q, ovt_l_q, hyst_q) &&
    released(remote_q, ovt_r_q, hyst_q)) |-> ##2 !overtemp_oe_out)
    else $error("overtemp pin held below hysteresis point");
  AST_ALERT_SET: assert property ((alarm_live && !masked_w && !second_mode_w) ##1
    (!masked_w && !second_mode_w) |=> limit_pin_oe_out)
    else $error("limit interrupt not driven on violation");
  AST_MASK: assert property ((masked_w && !second_mode_w) |=> !limit_pin_oe_out)
    else $error("masked limit interrupt still driven");
  AST_ALERT_HOLD: assert property ($fell(alert_q) |-> $past(serviced_q) &&
    ($past(status_q[6:2]) == 5'h00) && !$past(alarm_live))
    else $error("limit interrupt released before servicing");
  AST_OPEN_FLAG: assert property (open_w |=> status_q[ST_OPEN])
    else $error("open flag not set");
  AST_STICKY: assert property ((status_q[ST_LLO] && !status_rd) |=> status_q[ST_LLO])
    else $error("status flag lost without read");
  AST_LOW_HIT: assert property ((valid_q && $signed(local_q) <= $signed(llo_q))
    |=> status_q[ST_LLO])
    else $error("low limit violation not flagged");
  AST_STANDBY: assert property ((standby_w && !oneshot_q) |-> ##2 !busy_q)
    else $error("conversion still running in standby");
  AST_HOLD_VAL: assert property (!busy_q |=> $stable(local_q) && $stable(remote_q))
    else $error("value changed without a conversion");
  AST_ONESHOT: assert property ((oneshot_wr && standby_w) |=> oneshot_q [*2])
    else $error("one-shot request not held");
endmodule // tal_interrupt_logic

// ### test/tal_bus_master.sv
// Two-wire bus master model on an open-drain data line with pull-up
module tal_bus_master
  import tal_pkg::*;
(
  input wire logic clock_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Bit, frame and transaction cycles
  // ****************************************
  initial {scl_out, sda_out} = 2'b11;
  task automatic hold();
    repeat (10) @(posedge clock_in);
  endtask
  // Data only moves while the clock is low
  task automatic put(input logic b, output logic r);
    hold();
    sda_out <= b;
    hold();
    scl_out <= 1'b1;
    hold();
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  // Start when a=1,b=0; stop when a=0,b=1
  task automatic frame(input logic a, input logic b);
    hold();
    sda_out <= a;
    hold();
    scl_out <= 1'b1;
    hold();
    sda_out <= b;
    hold();
    if (!b) scl_out <= 1'b0;
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put(b[i], r);
    put(1'b1, r);
    ack = ~r;
  endtask
  // With has_data low only the pointer is set
  task automatic wr(input logic [7:0] p, input logic [7:0] v, input logic has_data,
                    output logic ok);
    logic a, b, c;
    c = 1'b1;
    frame(1'b1, 1'b0);
    tx({DEV_ADDR, 1'b0}, a);
    tx(p, b);
    if (has_data) tx(v, c);
    frame(1'b0, 1'b1);
    ok = a & b & c;
  endtask
  // One byte, closed by a no-acknowledge
  task automatic rd(input logic [6:0] a, output logic ok, output logic [7:0] d);
    logic r;
    d = 8'h00;
    frame(1'b1, 1'b0);
    tx({a, 1'b1}, ok);
    if (ok) begin
      for (int i = 7; i >= 0; i--) put(1'b1, d[i]);
      put(1'b1, r);
    end
    frame(1'b0, 1'b1);
  endtask
endmodule // tal_bus_master

// ### test/temp_alarm_interrupt_logic_bench.sv
// Self-checking bench of the temperature alarm and interrupt logic
module temp_alarm_interrupt_logic_bench
  import tal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Stimulus, converter model and checks
  // ****************************************
  typedef struct packed {logic [7:0] ptr; logic [7:0] val;} tal_row_t;
  // Reset contents; identity kept empty, unmapped pointer reads zero
  localparam tal_row_t ROWS [10] = '{'{RA_CONFIG, 8'h00}, '{RA_LHI, 8'h55},
    '{RA_LLO, 8'h00}, '{RA_RHI, 8'h55}, '{RA_RLO, 8'h00}, '{A_OVT_REMOTE, 8'h6c},
    '{A_OVT_LOCAL, 8'h55}, '{A_HYST, 8'h0a}, '{RA_ID, 8'h00}, '{8'h30, 8'h00}};
  localparam int GAP = 200;
  logic clock_in, nrst_in, adc_clk, adc_done, diode_open, ok;
  logic [7:0] adc_local, adc_remote, local_t, d;
  wire logic scl, m_sda, sda_oe, pin_oe, ot_oe, adc_start, s_o, p_o, t_o;
  wire logic sda_line = m_sda & ~sda_oe;
  int error_cnt, num_checks, conv_cnt, c;
  tal_bus_master u_master (.clock_in(clock_in), .sda_in(sda_line), .scl_out(scl),
    .sda_out(m_sda));
  tal_interrupt_logic #(.CONV_GAP(GAP)) u_dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .scl_in(scl), .sda_in(sda_line), .sda_o_out(s_o), .sda_oe_out(sda_oe),
    .adc_clk_in(adc_clk), .adc_done_in(adc_done), .adc_local_in(adc_local),
    .adc_remote_in(adc_remote), .diode_open_in(diode_open), .adc_start_out(adc_start),
    .limit_pin_o_out(p_o), .limit_pin_oe_out(pin_oe), .overtemp_o_out(t_o),
    .overtemp_oe_out(ot_oe));
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  initial begin
    adc_clk = 1'b0;
    #7;
    forever #62.5 adc_clk = ~adc_clk;
  end
  // Prompt converter; result lines scrambled outside the done cycle
  always @(posedge adc_clk) begin
    adc_done <= adc_start;
    adc_local <= adc_start ? local_t : ~local_t;
    adc_remote <= adc_start ? 8'h19 : 8'he6;
    if (adc_start) conv_cnt <= conv_cnt + 1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Two started conversions, then room for the crossing
  task automatic settle();
    c = conv_cnt;
    for (int i = 0; i < 5 * GAP && conv_cnt < c + 2; i++) @(posedge clock_in);
    if (conv_cnt < c + 2) begin
      error_cnt++;
      $display("mismatch at %0t: conversion timeout", $time);
      conclude();
    end
    repeat (10) @(posedge clock_in);
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] v);
    u_master.wr(p, v, 1'b1, ok);
    chk(8'(ok), 8'h01);
  endtask
  task automatic rreg(input logic [7:0] p);
    u_master.wr(p, 8'h00, 1'b0, ok);
    u_master.rd(DEV_ADDR, ok, d);
  endtask
  task automatic service();
    rreg(RA_STATUS);
    for (int i = 0; i < 3 && pin_oe === 1'b1; i++) u_master.rd(ARA_ADDR, ok, d);
  endtask
  initial begin
    nrst_in = 1'b0;
    local_t = 8'h19;
    diode_open = 1'b0;
    {adc_done, adc_local, adc_remote} = '0;
    {error_cnt, num_checks, conv_cnt} = '0;
    repeat (12) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    chk(8'({pin_oe, ot_oe, sda_oe, s_o, p_o, t_o}), 8'h00);
    foreach (ROWS[i]) begin
      rreg(ROWS[i].ptr);
      chk(d, ROWS[i].val);
    end
    u_master.rd(ARA_ADDR, ok, d);
    chk(8'(ok), 8'h00);
    wreg(A_HYST, 8'h05);
    rreg(A_HYST);
    chk(d, 8'h05);
    local_t <= 8'h5a;
    settle();
    chk(8'({pin_oe, ot_oe}), 8'h03);
    local_t <= 8'h51;
    settle();
    chk(8'(ot_oe), 8'h01);
    local_t <= 8'h50;
    settle();
    chk(8'({pin_oe, ot_oe}), 8'h02);
    u_master.rd(ARA_ADDR, ok, d);
    chk(d, 8'h99);
    chk(8'(pin_oe), 8'h01);
    rreg(RA_STATUS);
    chk(d & 8'h7f, 8'h41);
    service();
    chk(8'(pin_oe), 8'h00);
    wreg(WA_CONFIG, 8'h80);
    local_t <= 8'h5a;
    settle();
    chk(8'({pin_oe, ot_oe}), 8'h01);
    local_t <= 8'h50;
    settle();
    service();
    wreg(WA_CONFIG, 8'h40);
    repeat (20) @(posedge clock_in);
    c = conv_cnt;
    repeat (3 * GAP) @(posedge clock_in);
    chk(8'(conv_cnt - c), 8'h00);
    wreg(WA_ONESHOT, 8'h5a);
    repeat (3 * GAP) @(posedge clock_in);
    chk(8'(conv_cnt - c), 8'h01);
    wreg(WA_LHI, 8'h4b);
    repeat (10) @(posedge clock_in);
    chk(8'(pin_oe), 8'h01);
    wreg(WA_LHI, 8'h55);
    service();
    chk(8'(pin_oe), 8'h00);
    // Stored local value equals the new low limit
    wreg(WA_LLO, 8'h50);
    repeat (10) @(posedge clock_in);
    chk(8'(pin_oe), 8'h01);
    rreg(RA_STATUS);
    chk(d & 8'h20, 8'h20);
    wreg(WA_LLO, 8'h00);
    service();
    chk(8'(pin_oe), 8'h00);
    wreg(WA_CONFIG, 8'h20);
    local_t <= 8'h57;
    settle();
    chk(8'(pin_oe), 8'h01);
    local_t <= 8'h50;
    settle();
    chk(8'(pin_oe), 8'h00);
    wreg(WA_CONFIG, 8'h00);
    // Alert latched while in second mode must be serviced first
    service();
    chk(8'(pin_oe), 8'h00);
    diode_open <= 1'b1;
    settle();
    chk(8'(pin_oe), 8'h01);
    chk(8'({s_o, p_o, t_o}), 8'h00);
    rreg(RA_STATUS);
    chk(d & 8'h04, 8'h04);
    conclude();
  end
endmodule // temp_alarm_interrupt_logic_bench
